// File: pvc_phy_vendor_regs.sv
// pvc_phy_vendor_regs: vendor management registers 18, 27, 29, 30, 31
// reached through the serial management pins; line status from PHY core
// Operation
// - override clear: strap pin picks auto crossover; set: bits 14,13 decide
// - override set: bit 14 enables auto crossover, else bit 13 selects
// - manual mode: bit 13 zero straight pairs, one swapped pairs
// - bit 10 locks 10M receive PLL to reference, survives soft reset
// - bit 4 reports 10BASE-T receive polarity live from the PHY core, not reset
// - bits 3:0 read-only, writes ignored; reserved bits write zero
// - source bit 7 on energy-on, bit 6 on negotiation complete
// - source bit 5 on remote fault, bit 4 on link down
// - link-down flag after reset follows current line link state
// - bit 3 partner ack, bit 2 parallel fault, bit 1 page received
// - mask register bits 7:0 enable sources, reset zero, upper zero
// - status bit 12 reads one only when negotiation has finished
// - status bits 4:2 report resolved speed and duplex code
// - registers sit at indices 18, 27, 29, 30, 31, sixteen bits wide
// - answer only at held 5-bit address, default 00001, keeps on soft reset
// - energy indication falls after 256 ms quiet, hardware reset sets it
`timescale 1ns/100ps
module pvc_phy_vendor_regs #(
  parameter int ENERGY_TIMEOUT_CYC = pvc_pkg::ENERGY_TIMEOUT_CYC
) (
  // clock and resets
  input  wire logic                      mclk,
  input  wire logic                      resetn,
  input  wire logic                      soft_reset,
  // management pins
  input  wire logic                      mdc,
  input  wire logic                      mdio_in,
  output logic                           mdio_out,
  output logic                           mdio_oe,
  // straps and line pins
  input  wire logic                      crossover_strap_pin,
  input  wire logic                      line_energy,
  // PHY core status
  input  wire pvc_pkg::pvc_line_status_s line_status,
  // controls towards the PHY core
  output pvc_pkg::pvc_xover_s            xover_ctrl,
  output logic [4:0]                     phy_mgmt_addr,
  output logic                           energy_detected,
  // interrupt towards the MAC
  output logic                           phy_irq
);

  // ---------------------------------------------------------------
  // pin synchronisers: mdc, mdio, strap, energy
  // ---------------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic       mdc_prev_q;
  logic       bit_prev_q;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      sync1_q    <= 4'h0;
      sync2_q    <= 4'h0;
      // seen as high, yet the synchronisers reset low, so an mdc idling high gives one rise after release
      mdc_prev_q <= 1'h1;
    end
    else
    begin
      sync1_q    <= {line_energy, crossover_strap_pin, mdio_in, mdc};
      sync2_q    <= sync1_q;
      mdc_prev_q <= sync2_q[0];
    end
  end

  // mdc must stay over one mclk high and over one low, or a rise is lost
  wire mdc_rise    = sync2_q[0] & ~mdc_prev_q;
  wire mdio_bit    = sync2_q[1];
  wire strap_level = sync2_q[2];
  wire energy_seen = sync2_q[3];

  // ---------------------------------------------------------------
  // energy-detected level
  // ---------------------------------------------------------------
  pvc_energy_watch #(
    .TIMEOUT_CYC (ENERGY_TIMEOUT_CYC)
  ) u_energy (
    .mclk            (mclk),
    .resetn          (resetn),
    .energy_seen     (energy_seen),
    .energy_detected (energy_detected)
  );

  // ---------------------------------------------------------------
  // management frame receiver and read shifter
  // ---------------------------------------------------------------
  pvc_pkg::pvc_mdio_state_e state_q;
  logic [4:0]               cnt_q;
  logic [11:0]              hdr_q;
  logic [15:0]              data_q;
  logic                     out_q;
  logic                     oe_q;

  // header layout: op[11:10], phy address[9:5], register index[4:0]
  wire [1:0] hdr_op  = hdr_q[11:10];
  wire [4:0] hdr_phy = hdr_q[9:5];
  wire [4:0] hdr_reg = hdr_q[4:0];

  // index decode, shared by the answer check, the writes and the read mux
  wire sel_modes = (hdr_reg == pvc_pkg::REG_SPECIAL_MODES);
  wire sel_xover = (hdr_reg == pvc_pkg::REG_XOVER);
  wire sel_src   = (hdr_reg == pvc_pkg::REG_IRQ_SRC);
  wire sel_mask  = (hdr_reg == pvc_pkg::REG_IRQ_MASK);
  wire sel_link  = (hdr_reg == pvc_pkg::REG_LINK_STAT);

  logic [4:0] addr_q;
  wire        addr_hit = (hdr_phy == addr_q);
  // indices 0-17 belong to another block, so the pin stays released there
  wire        reg_hit  = sel_modes | sel_xover | sel_src |
                         sel_mask | sel_link;
  wire        our_read  = addr_hit & reg_hit & (hdr_op == pvc_pkg::OP_READ);
  wire        our_write = addr_hit & reg_hit & (hdr_op == pvc_pkg::OP_WRITE);

  wire ta_first  = mdc_rise && (state_q == pvc_pkg::MD_TA) && (cnt_q == 5'h00);
  wire ta_second = mdc_rise && (state_q == pvc_pkg::MD_TA) && (cnt_q != 5'h00);
  wire data_step = mdc_rise && (state_q == pvc_pkg::MD_DATA);
  wire frame_end = data_step && (cnt_q == pvc_pkg::DATA_LAST);

  wire [15:0] wdata  = {data_q[14:0], mdio_bit};
  wire        wr_stb = frame_end & our_write;
  wire        rd_end = frame_end & our_read;

  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      state_q    <= pvc_pkg::MD_IDLE;
      cnt_q      <= 5'h00;
      hdr_q      <= 12'h000;
      bit_prev_q <= 1'h0;
    end
    else if (mdc_rise)
    begin
      bit_prev_q <= mdio_bit;
      unique case (state_q)
        // preamble length is not checked: any 1 then 0 starts a frame
        pvc_pkg::MD_IDLE:
          if (bit_prev_q && !mdio_bit)
            state_q <= pvc_pkg::MD_START;
        pvc_pkg::MD_START:
        begin
          cnt_q   <= 5'h00;
          state_q <= mdio_bit ? pvc_pkg::MD_HDR : pvc_pkg::MD_IDLE;
        end
        pvc_pkg::MD_HDR:
        begin
          hdr_q <= {hdr_q[10:0], mdio_bit};
          cnt_q <= (cnt_q == pvc_pkg::HDR_LAST) ? 5'h00 : cnt_q + 5'h01;
          if (cnt_q == pvc_pkg::HDR_LAST)
            state_q <= pvc_pkg::MD_TA;
        end
        pvc_pkg::MD_TA:
        begin
          cnt_q <= (cnt_q == 5'h00) ? 5'h01 : 5'h00;
          if (cnt_q != 5'h00)
            state_q <= pvc_pkg::MD_DATA;
        end
        pvc_pkg::MD_DATA:
        begin
          cnt_q <= cnt_q + 5'h01;
          if (cnt_q == pvc_pkg::DATA_LAST)
            state_q <= pvc_pkg::MD_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // control registers
  // ---------------------------------------------------------------
  logic [2:0] xctl_q;     // override, auto enable, manual state
  logic       pll_q;
  logic [7:0] mask_q;
  logic [6:0] link_rsv_q;

  // the modes index keeps only the address; its upper bits read zero
  wire wr_modes = wr_stb && sel_modes;
  wire wr_xover = wr_stb && sel_xover;
  wire wr_mask  = wr_stb && sel_mask;
  wire wr_link  = wr_stb && sel_link;

  // address and PLL lock are kept across soft reset
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      addr_q <= pvc_pkg::PHY_ADDR_RST;
      pll_q  <= 1'h0;
    end
    else
    begin
      if (wr_modes)
        addr_q <= wdata[4:0];
      if (wr_xover)
        pll_q  <= wdata[pvc_pkg::XOVER_PLL_BIT];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!resetn || soft_reset)
    begin
      xctl_q     <= pvc_pkg::XCTL_RST;
      mask_q     <= pvc_pkg::MASK_RST;
      link_rsv_q <= pvc_pkg::LINK_RSV_RST;
    end
    else
    begin
      if (wr_xover)
        xctl_q <= wdata[pvc_pkg::XOVER_OVERRIDE_BIT:pvc_pkg::XOVER_STATE_BIT];
      if (wr_mask)
        mask_q <= wdata[7:0];
      if (wr_link)
        link_rsv_q <= wdata[pvc_pkg::LINK_RSV_LSB +: 7];
    end
  end

  // ---------------------------------------------------------------
  // crossover selection
  // ---------------------------------------------------------------
  wire xo_override = xctl_q[2];
  wire xo_auto     = xctl_q[1];
  wire xo_state    = xctl_q[0];

  // with auto enabled bit 13 is ignored, so the forbidden code acts as auto
  assign xover_ctrl.auto_mdix_en = xo_override ? xo_auto : strap_level;
  assign xover_ctrl.crossover    = xo_override & ~xo_auto & xo_state;
  assign xover_ctrl.rx_pll_ref_lock = pll_q;
  assign phy_mgmt_addr = addr_q;

  // ---------------------------------------------------------------
  // interrupt source flags
  // ---------------------------------------------------------------
  logic [7:1] src_q;
  logic [7:1] src_shown_q;
  logic [5:0] ev_prev_q;

  wire [5:0] ev_now = {energy_detected,
                       line_status.an_done,
                       line_status.remote_fault,
                       line_status.lp_ack,
                       line_status.parallel_fault,
                       line_status.page_received};
  wire [5:0] ev_rise = ev_now & ~ev_prev_q;

  // link down is a level: it re-sets the flag while the link stays down,
  // which also gives the flag its post-reset value from the line state
  wire [7:1] src_set = {ev_rise[5],
                        ev_rise[4],
                        ev_rise[3],
                        ~line_status.link_up,
                        ev_rise[2],
                        ev_rise[1],
                        ev_rise[0]};

  // only the bits actually returned by the read are cleared, so an event
  // that lands during the data phase is kept for the next read
  wire [7:1] src_clr = (rd_end && sel_src) ?
                       src_shown_q : 7'h00;

  always_ff @(posedge mclk)
  begin
    if (!resetn || soft_reset)
    begin
      src_q     <= 7'h00;
      // history takes the live levels: energy comes out of reset high and
      // must not pass for a fresh energy-on event
      ev_prev_q <= ev_now;
    end
    else
    begin
      // set wins over the read clear, so an event in the clearing cycle stays
      src_q     <= (src_q & ~src_clr) | src_set;
      ev_prev_q <= ev_now;
    end
  end

  assign phy_irq = |({src_q, 1'h0} & mask_q);

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  wire [15:0] rd_modes = {11'h000, addr_q};
  wire [15:0] rd_xover = {xctl_q, 2'h0, pll_q, 5'h00,
                          line_status.rx_polarity_reversed,
                          4'h0};
  wire [15:0] rd_src   = {8'h00, src_q, 1'h0};
  wire [15:0] rd_mask  = {8'h00, mask_q};
  wire [15:0] rd_link  = {3'h0,
                          line_status.an_done,
                          link_rsv_q,
                          line_status.resolved_speed_duplex,
                          2'h0};

  // taken at the second turnaround bit, while the index still stands
  wire [15:0] rd_word =
    sel_modes ? rd_modes :
    sel_xover ? rd_xover :
    sel_src   ? rd_src   :
    sel_mask  ? rd_mask  :
    sel_link  ? rd_link  : 16'h0000;

  // pin driver: bit 15 goes out with the second turnaround bit
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      data_q      <= 16'h0000;
      out_q       <= 1'h1;
      oe_q        <= 1'h0;
      src_shown_q <= 7'h00;
    end
    else if (ta_first)
    begin
      out_q <= 1'h0;
      oe_q  <= our_read;
    end
    else if (ta_second)
    begin
      out_q       <= rd_word[15];
      data_q      <= {rd_word[14:0], 1'h0};
      src_shown_q <= src_q;
    end
    else if (data_step)
    begin
      out_q  <= oe_q ? data_q[15] : 1'h1;
      data_q <= oe_q ? {data_q[14:0], 1'h0} : wdata;
      if (frame_end)
        oe_q <= 1'h0;
    end
  end

  assign mdio_out = out_q;
  assign mdio_oe  = oe_q;

endmodule : pvc_phy_vendor_regs

// File: pvc_pkg.sv
// pvc_pkg: constants, carriers and states of the vendor management registers
// assumes a 10 MHz management clock and a 5-bit serial management address
package pvc_pkg;

  // timing
  localparam int CLK_HZ             = 10_000_000;
  localparam int ENERGY_TIMEOUT_MS  = 256;
  localparam int ENERGY_TIMEOUT_CYC = ENERGY_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int ENERGY_CNT_W       = 22;

  // register indices
  localparam logic [4:0] REG_SPECIAL_MODES = 5'h12;
  localparam logic [4:0] REG_XOVER         = 5'h1B;
  localparam logic [4:0] REG_IRQ_SRC       = 5'h1D;
  localparam logic [4:0] REG_IRQ_MASK      = 5'h1E;
  localparam logic [4:0] REG_LINK_STAT     = 5'h1F;

  // crossover_control_status fields
  localparam int XOVER_OVERRIDE_BIT = 15;
  localparam int XOVER_AUTO_BIT     = 14;
  localparam int XOVER_STATE_BIT    = 13;
  localparam int XOVER_PLL_BIT      = 10;
  localparam int XOVER_POL_BIT      = 4;

  // special_link_status fields
  localparam int         LINK_AN_DONE_BIT = 12;
  localparam int         LINK_RSV_LSB     = 5;
  localparam int         LINK_SPD_LSB     = 2;
  localparam logic [6:0] LINK_RSV_RST     = 7'h02;

  // interrupt source bit positions
  localparam int SRC_ENERGY_ON      = 7;
  localparam int SRC_AN_COMPLETE    = 6;
  localparam int SRC_REMOTE_FAULT   = 5;
  localparam int SRC_LINK_DOWN      = 4;
  localparam int SRC_LP_ACK         = 3;
  localparam int SRC_PARALLEL_FAULT = 2;
  localparam int SRC_PAGE_RECEIVED  = 1;

  // reset values
  localparam logic [4:0] PHY_ADDR_RST = 5'h01;
  localparam logic [7:0] MASK_RST     = 8'h00;
  localparam logic [2:0] XCTL_RST     = 3'h0;

  // resolved speed and duplex codes
  localparam logic [2:0] SPD_10_HALF  = 3'h1;
  localparam logic [2:0] SPD_10_FULL  = 3'h5;
  localparam logic [2:0] SPD_100_HALF = 3'h2;
  localparam logic [2:0] SPD_100_FULL = 3'h6;

  // management frame
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [4:0] HDR_LAST  = 5'h0B;
  localparam logic [4:0] DATA_LAST = 5'h0F;

  typedef struct packed {
    logic       link_up;
    logic       an_done;
    logic       remote_fault;
    logic       lp_ack;
    logic       parallel_fault;
    logic       page_received;
    logic       rx_polarity_reversed;
    logic [2:0] resolved_speed_duplex;
  } pvc_line_status_s;

  typedef struct packed {
    logic auto_mdix_en;
    logic crossover;
    logic rx_pll_ref_lock;
  } pvc_xover_s;

  typedef enum logic [2:0] {
    MD_IDLE,
    MD_START,
    MD_HDR,
    MD_TA,
    MD_DATA
  } pvc_mdio_state_e;

endpackage : pvc_pkg

// File: pvc_energy_watch.sv
// pvc_energy_watch: holds the energy-detected level of the line
// assumes energy_seen is already synchronised to mclk
`timescale 1ns/100ps
module pvc_energy_watch #(
  parameter int TIMEOUT_CYC = pvc_pkg::ENERGY_TIMEOUT_CYC
) (
  // clock and hardware reset
  input  wire logic mclk,
  input  wire logic resetn,
  // line
  input  wire logic energy_seen,
  output logic      energy_detected
);

  localparam logic [pvc_pkg::ENERGY_CNT_W-1:0] LAST =
    pvc_pkg::ENERGY_CNT_W'(TIMEOUT_CYC - 1);

  logic [pvc_pkg::ENERGY_CNT_W-1:0] quiet_q;
  logic                             det_q;

  wire timed_out = (quiet_q == LAST);

  // only the hardware reset reaches here; soft reset leaves the level alone
  always_ff @(posedge mclk)
  begin
    if (!resetn)
    begin
      quiet_q <= '0;
      det_q   <= 1'h1;
    end
    else if (energy_seen)
    begin
      quiet_q <= '0;
      det_q   <= 1'h1;
    end
    else if (timed_out)
      det_q   <= 1'h0;
    else
      quiet_q <= quiet_q + 1'h1;
  end

  assign energy_detected = det_q;

endmodule : pvc_energy_watch

// File: pvc_phy_vendor_regs_monitor.sv
// pvc_phy_vendor_regs_monitor: port-level assertions for the vendor registers
// assumes a bind onto pvc_phy_vendor_regs, all on the one mclk domain
`timescale 1ns/100ps
module pvc_phy_vendor_regs_monitor #(
  parameter int ENERGY_TIMEOUT_CYC = 20
) (
  // clock and resets
  input wire logic                mclk,
  input wire logic                resetn,
  input wire logic                soft_reset,
  // management data
  input wire logic                mdio_out,
  input wire logic                mdio_oe,
  // line and controls
  input wire logic                line_energy,
  input wire pvc_pkg::pvc_xover_s xover_ctrl,
  input wire logic [4:0]          phy_mgmt_addr,
  input wire logic                energy_detected,
  input wire logic                phy_irq
);
  // saturating count of quiet cycles; margin covers the input synchroniser
  int low_cnt;
  always_ff @(posedge mclk)
  begin
    if (!resetn || line_energy)
      low_cnt <= 0;
    else if (low_cnt < ENERGY_TIMEOUT_CYC + 8)
      low_cnt <= low_cnt + 1;
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  AST_RESET_ADDR: assert property ($rose(resetn) |-> phy_mgmt_addr == 5'h01)
    else $error("address not at default after reset");
  AST_RESET_ENERGY: assert property ($rose(resetn) |-> energy_detected)
    else $error("energy indication low after reset");
  AST_RESET_QUIET: assert property ($rose(resetn) |->
    !phy_irq && !xover_ctrl.rx_pll_ref_lock && !mdio_oe)
    else $error("irq, pll lock or data drive active after reset");
  AST_CROSS_MANUAL: assert property (xover_ctrl.crossover |->
    !xover_ctrl.auto_mdix_en)
    else $error("pairs swapped while auto crossover enabled");
  AST_ENERGY_RISE: assert property (line_energy [*6] |-> energy_detected)
    else $error("energy indication missing with energy present");
  AST_ENERGY_TIMEOUT: assert property
    (low_cnt == ENERGY_TIMEOUT_CYC + 8 |-> !energy_detected)
    else $error("energy indication held past quiet timeout");
  AST_SOFT_KEEPS: assert property (soft_reset |=>
    $stable(phy_mgmt_addr) && $stable(xover_ctrl.rx_pll_ref_lock))
    else $error("soft reset disturbed address or pll lock");
  AST_SOFT_IRQ_OFF: assert property (soft_reset |=> !phy_irq)
    else $error("irq active after soft reset cleared mask");
  AST_OE_HOLD: assert property ($rose(mdio_oe) |->
    !mdio_out ##1 mdio_oe [*8])
    else $error("read turnaround not driven low or drive too short");

  cover property ($rose(mdio_oe));
  cover property ($rose(phy_irq));
  cover property ($fell(energy_detected));
endmodule : pvc_phy_vendor_regs_monitor

// File: pvc_mdio_master.sv
// pvc_mdio_master: behavioural management master, drives mdc and data
// assumes the bench resolves the shared data line with a pull-up
`timescale 1ns/100ps
module pvc_mdio_master #(
  parameter int HALF = 5
) (
  // clock
  input  wire logic mclk,
  // resolved data line
  input  wire logic line,
  // master pins
  output logic      mdc,
  output logic      drv,
  output logic      val
);
  initial
  begin
    mdc = 1'h0;
    drv = 1'h0;
    val = 1'h1;
  end

  // data changes while mdc is low, sampled just before the rise
  task automatic clk_bit(input logic d, input logic v, output logic s);
    @(negedge mclk);
    mdc = 1'h0;
    drv = d;
    val = v;
    repeat (HALF - 1) @(negedge mclk);
    s = line;
    mdc = 1'h1;
    repeat (HALF) @(negedge mclk);
  endtask : clk_bit

  // on a read the line is released from the first turnaround bit on
  task automatic frame(input logic rd, input logic [4:0] pa,
                       input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rdat);
    logic [13:0] hdr;
    logic        s;
    hdr = {2'h1, rd ? pvc_pkg::OP_READ : pvc_pkg::OP_WRITE, pa, ra};
    repeat (4) clk_bit(1'h1, 1'h1, s);
    for (int i = 13; i >= 0; i--)
      clk_bit(1'h1, hdr[i], s);
    clk_bit(!rd, 1'h1, s);
    clk_bit(!rd, 1'h0, s);
    for (int i = 15; i >= 0; i--)
    begin
      clk_bit(!rd, wd[i], s);
      rdat[i] = s;
    end
    clk_bit(1'h0, 1'h1, s);
  endtask : frame
endmodule : pvc_mdio_master

// File: pvc_phy_vendor_regs_test.sv
// pvc_phy_vendor_regs_test: self-checking bench for the vendor registers
// assumes pvc_mdio_master as partner and a pulled-up management data line
`timescale 1ns/100ps
module pvc_phy_vendor_regs_test;
  localparam int TO_CYC = 20;
  typedef struct packed {
    logic [4:0]  ra;
    logic [15:0] wd;
    logic [15:0] rx;
    logic [2:0]  xo;
  } pvc_row_s;

  logic                      mclk, resetn, soft_reset, mdc, mdio_line;
  logic                      mdio_out, mdio_oe, m_drv, m_val, strap;
  logic                      line_energy, energy_detected, phy_irq;
  logic [4:0]                addr, pa;
  pvc_pkg::pvc_line_status_s ls;
  pvc_pkg::pvc_xover_s       xo;
  int                        n_errors, total_checks;
  logic [2:0]                spd [4] = '{pvc_pkg::SPD_10_HALF,
    pvc_pkg::SPD_10_FULL, pvc_pkg::SPD_100_HALF, pvc_pkg::SPD_100_FULL};
  pvc_row_s                  rows [9] = '{
    '{pvc_pkg::REG_XOVER, 16'hC000, 16'hC000, 3'h4},
    '{pvc_pkg::REG_XOVER, 16'h8000, 16'h8000, 3'h0},
    '{pvc_pkg::REG_XOVER, 16'hA000, 16'hA000, 3'h2},
    '{pvc_pkg::REG_XOVER, 16'h0400, 16'h0400, 3'h5},
    '{pvc_pkg::REG_XOVER, 16'h000F, 16'h0000, 3'h4},
    '{pvc_pkg::REG_IRQ_MASK, 16'hFFFF, 16'h00FF, 3'h4},
    '{pvc_pkg::REG_IRQ_MASK, 16'h00A5, 16'h00A5, 3'h4},
    '{pvc_pkg::REG_LINK_STAT, 16'h0040, 16'h0058, 3'h4},
    '{5'h10, 16'h1234, 16'hFFFF, 3'h4}};

  // pull-up wins only when nobody drives
  assign mdio_line = mdio_oe ? mdio_out : (m_drv ? m_val : 1'h1);

  pvc_phy_vendor_regs #(.ENERGY_TIMEOUT_CYC(TO_CYC)) pvc_phy_vendor_regs_i (
    .mclk(mclk), .resetn(resetn), .soft_reset(soft_reset), .mdc(mdc),
    .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .crossover_strap_pin(strap), .line_energy(line_energy),
    .line_status(ls), .xover_ctrl(xo), .phy_mgmt_addr(addr),
    .energy_detected(energy_detected), .phy_irq(phy_irq));
  pvc_mdio_master #(.HALF(5)) pvc_mdio_master_i (
    .mclk(mclk), .line(mdio_line), .mdc(mdc), .drv(m_drv), .val(m_val));

  task automatic chk(input string what, input logic [15:0] got,
                     input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [4:0] ra, input logic [15:0] v);
    logic [15:0] dummy;
    pvc_mdio_master_i.frame(1'h0, pa, ra, v, dummy);
  endtask : wr

  task automatic rchk(input string what, input logic [4:0] ra,
                      input logic [15:0] exp);
    logic [15:0] v;
    pvc_mdio_master_i.frame(1'h1, pa, ra, 16'h0000, v);
    chk(what, v, exp);
  endtask : rchk

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop

  // bounded wait; the bound is the allowed synchroniser and timeout slack
  task automatic wait_energy(input logic lvl, input int lim);
    int k;
    k = 0;
    while (energy_detected !== lvl && k < lim)
    begin
      @(negedge mclk);
      k++;
    end
    if (k == lim)
    begin
      n_errors++;
      $display("mismatch energy wait expected %h seen %h", lvl,
               energy_detected);
      report_and_stop();
    end
  endtask : wait_energy

  initial
  begin
    mclk = 1'h0;
    forever #50 mclk = ~mclk;
  end

  initial
  begin
    repeat (100000) @(posedge mclk);
    n_errors++;
    $display("mismatch watchdog expected done seen hang");
    report_and_stop();
  end

  initial
  begin
    resetn = 1'h0;
    soft_reset = 1'h0;
    strap = 1'h1;
    line_energy = 1'h1;
    ls = '0;
    ls.resolved_speed_duplex = pvc_pkg::SPD_100_FULL;
    pa = pvc_pkg::PHY_ADDR_RST;
    n_errors = 0;
    total_checks = 0;
    repeat (16) @(negedge mclk);
    resetn = 1'h1;
    repeat (4) @(negedge mclk);
    chk("addr", {11'h000, addr}, 16'h0001);
    chk("energy", {15'h0000, energy_detected}, 16'h0001);
    chk("xover ctrl", {13'h0000, xo}, 16'h0004);
    rchk("mask", pvc_pkg::REG_IRQ_MASK, 16'h0000);
    rchk("xover reg", pvc_pkg::REG_XOVER, 16'h0000);
    rchk("link stat", pvc_pkg::REG_LINK_STAT, 16'h0058);
    rchk("src", pvc_pkg::REG_IRQ_SRC, 16'h0010);
    rchk("src", pvc_pkg::REG_IRQ_SRC, 16'h0010);
    ls.link_up = 1'h1;
    rchk("src", pvc_pkg::REG_IRQ_SRC, 16'h0010);
    rchk("src", pvc_pkg::REG_IRQ_SRC, 16'h0000);
    $display("test reset done");
    // software never writes 15:13 all set and keeps 31.11:5 at 0000010
    foreach (rows[i])
    begin
      wr(rows[i].ra, rows[i].wd);
      rchk("row read", rows[i].ra, rows[i].rx);
      chk("row xover", {13'h0000, xo}, {13'h0000, rows[i].xo});
    end
    $display("test rows done");
    ls.rx_polarity_reversed = 1'h1;
    ls.remote_fault = 1'h1;
    @(negedge mclk);
    ls.remote_fault = 1'h0;
    repeat (3) @(negedge mclk);
    chk("irq", {15'h0000, phy_irq}, 16'h0001);
    ls.an_done = 1'h1;
    ls.lp_ack = 1'h1;
    ls.parallel_fault = 1'h1;
    ls.page_received = 1'h1;
    @(negedge mclk);
    ls.lp_ack = 1'h0;
    ls.parallel_fault = 1'h0;
    ls.page_received = 1'h0;
    line_energy = 1'h0;
    repeat (TO_CYC - 2) @(negedge mclk);
    chk("energy", {15'h0000, energy_detected}, 16'h0001);
    wait_energy(1'h0, 12);
    line_energy = 1'h1;
    wait_energy(1'h1, 6);
    rchk("src", pvc_pkg::REG_IRQ_SRC, 16'h00EE);
    rchk("src", pvc_pkg::REG_IRQ_SRC, 16'h0000);
    chk("irq", {15'h0000, phy_irq}, 16'h0000);
    rchk("polarity", pvc_pkg::REG_XOVER, 16'h0010);
    foreach (spd[i])
    begin
      ls.resolved_speed_duplex = spd[i];
      rchk("speed", pvc_pkg::REG_LINK_STAT,
           {3'h0, 1'h1, 7'h02, spd[i], 2'h0});
    end
    ls.remote_fault = 1'h1;
    @(negedge mclk);
    ls.remote_fault = 1'h0;
    repeat (3) @(negedge mclk);
    chk("irq", {15'h0000, phy_irq}, 16'h0001);
    wr(pvc_pkg::REG_IRQ_MASK, 16'h0000);
    chk("irq", {15'h0000, phy_irq}, 16'h0000);
    rchk("src", pvc_pkg::REG_IRQ_SRC, 16'h0020);
    $display("test events done");
    wr(pvc_pkg::REG_XOVER, 16'h8400);
    wr(pvc_pkg::REG_IRQ_MASK, 16'h00FF);
    wr(pvc_pkg::REG_SPECIAL_MODES, 16'h0005);
    rchk("old addr", pvc_pkg::REG_XOVER, 16'hFFFF);
    pa = 5'h05;
    rchk("new addr", pvc_pkg::REG_XOVER, 16'h8410);
    soft_reset = 1'h1;
    @(negedge mclk);
    soft_reset = 1'h0;
    repeat (2) @(negedge mclk);
    rchk("kept pll", pvc_pkg::REG_XOVER, 16'h0410);
    rchk("mask", pvc_pkg::REG_IRQ_MASK, 16'h0000);
    chk("addr", {11'h000, addr}, 16'h0005);
    chk("xover ctrl", {13'h0000, xo}, 16'h0005);
    chk("energy", {15'h0000, energy_detected}, 16'h0001);
    rchk("src", pvc_pkg::REG_IRQ_SRC, 16'h0000);
    $display("test soft reset done");
    resetn = 1'h0;
    repeat (16) @(negedge mclk);
    resetn = 1'h1;
    pa = pvc_pkg::PHY_ADDR_RST;
    repeat (4) @(negedge mclk);
    chk("addr", {11'h000, addr}, 16'h0001);
    chk("xover ctrl", {13'h0000, xo}, 16'h0004);
    rchk("pll reset", pvc_pkg::REG_XOVER, 16'h0010);
    rchk("src", pvc_pkg::REG_IRQ_SRC, 16'h0000);
    $display("test hard reset done");
    report_and_stop();
  end
endmodule : pvc_phy_vendor_regs_test

bind pvc_phy_vendor_regs pvc_phy_vendor_regs_monitor #(
  .ENERGY_TIMEOUT_CYC(ENERGY_TIMEOUT_CYC)
) pvc_phy_vendor_regs_monitor_i (
  .mclk(mclk), .resetn(resetn), .soft_reset(soft_reset),
  .mdio_out(mdio_out), .mdio_oe(mdio_oe), .line_energy(line_energy),
  .xover_ctrl(xover_ctrl), .phy_mgmt_addr(phy_mgmt_addr),
  .energy_detected(energy_detected), .phy_irq(phy_irq));
